// ==== sensor_fifo_pkg.sv ====
package sensor_fifo_pkg;
  // ----------------------------------------------------------------
  // Register map (7-bit register addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_DOWNS   = 7'h45;
  localparam logic [6:0] ADDR_WTM_LO  = 7'h46;
  localparam logic [6:0] ADDR_WTM_HI  = 7'h47;
  localparam logic [6:0] ADDR_CFG_A   = 7'h48;
  localparam logic [6:0] ADDR_CFG_B   = 7'h49;
  localparam logic [6:0] ADDR_AUX_ID  = 7'h4B;
  // Reset values
  localparam logic [7:0] RST_DOWNS    = 8'h80;
  localparam logic [7:0] RST_WTM_LO   = 8'h00;
  localparam logic [7:0] RST_WTM_HI   = 8'h02;
  localparam logic [7:0] RST_CFG_A    = 8'h02;
  localparam logic [7:0] RST_CFG_B    = 8'h10;
  localparam logic [7:0] RST_AUX_ID   = 8'h20;
  // Writable bit masks, reserved bits read as zero
  localparam logic [7:0] MASK_DOWNS   = 8'hF0;
  localparam logic [7:0] MASK_WTM_HI  = 8'h1F;
  localparam logic [7:0] MASK_CFG_A   = 8'h03;
  localparam logic [7:0] MASK_CFG_B   = 8'h7C;
  localparam logic [7:0] MASK_AUX_ID  = 8'hFE;
  // Field positions
  localparam int BIT_FILT      = 7;
  localparam int BIT_DS_LO     = 4;
  localparam int BIT_STOP_FULL = 0;
  localparam int BIT_TIME_EN   = 1;
  localparam int BIT_ACC_EN    = 6;
  localparam int BIT_AUX_EN    = 5;
  localparam int BIT_HDR_EN    = 4;
  localparam int BIT_TAG_A     = 3;
  localparam int BIT_TAG_B     = 2;
  // Frame word layout
  localparam int AXIS_W   = 48;
  localparam int FRAME_W  = 2 * AXIS_W + 6;
  localparam int F_TIME   = FRAME_W - 1;
  localparam int F_HDR    = FRAME_W - 2;
  localparam int F_TAG_A  = FRAME_W - 3;
  localparam int F_TAG_B  = FRAME_W - 4;
  localparam int F_ACC    = FRAME_W - 5;
  localparam int F_AUX    = FRAME_W - 6;
  localparam int FIFO_DEPTH = 8;
  // Byte sizes of frame parts
  localparam logic [12:0] BYTES_HDR  = 13'h0001;
  localparam logic [12:0] BYTES_AXES = 13'h0006;
  localparam logic [12:0] BYTES_TIME = 13'h0003;
endpackage

// ==== sensor_fifo_config.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Frame FIFO with optional overwrite of the oldest entry
// ------------------------------------------------------------------
module frame_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  input  wire logic         overwrite,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              full
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop, drop;

  // Full accepts only when the oldest entry may be dropped
  assign full      = (cnt_ff == (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign in_ready  = !full || overwrite;
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign drop      = push && full && !pop;

  // Pointer and count update
  always_comb begin
    nxt_wr_ptr = push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
    nxt_rd_ptr = (pop || drop) ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
    nxt_cnt    = cnt_ff;
    if (push && !pop && !drop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule

// What this block does
// [RULE1] Downsample accelerometer by two to the field
// [RULE2] Select raw or filtered samples, filtered default
// [RULE3] Watermark low byte, read-write, resets zero
// [RULE4] Watermark bits 12..8, reset level 512
// [RULE5] Stop-on-full ceases writing; otherwise keep writing
// [RULE6] Sensor-time frame after last data frame
// [RULE7] Header stored per frame when enabled
// [RULE8] Host matches data rates before disabling headers
// [RULE9] Aux store bit stores all three aux axes
// [RULE10] Acc store bit stores all three acc axes
// [RULE11] Tag frames with first interrupt line state
// [RULE12] Tag frames with second interrupt line state
// [RULE13] Seven-bit aux slave address, resets 0x20
// [RULE14] Overwrite oldest frame when full, no stop
// [RULE15] Watermark event when fill bytes reach level
module sensor_fifo_config (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register port from the serial host interface
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [6:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata,
  // Sample sources
  input  wire logic                 acc_valid,
  input  wire logic [47:0]          acc_raw_data,
  input  wire logic [47:0]          acc_filt_data,
  input  wire logic                 aux_valid,
  input  wire logic [47:0]          aux_data,
  input  wire logic [23:0]          sensor_time,
  output logic                      sample_ready,
  // Interrupt line levels (pins)
  input  wire logic                 irq_line_a,
  input  wire logic                 irq_line_b,
  // Frame read-out
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [sensor_fifo_pkg::FRAME_W-1:0] out_data,
  // Status and configuration outputs
  output logic                      fifo_full,
  output logic [12:0]               fill_bytes,
  output logic                      wtm_event,
  output logic [6:0]                aux_slave_addr
);
  localparam int FW = sensor_fifo_pkg::FRAME_W;

  // Byte size of one stored frame
  function automatic logic [12:0] frame_bytes(input logic [FW-1:0] f);
    logic [12:0] n;
    n = f[sensor_fifo_pkg::F_HDR] ? sensor_fifo_pkg::BYTES_HDR : 13'h0000;
    if (f[sensor_fifo_pkg::F_TIME]) n = n + sensor_fifo_pkg::BYTES_TIME;
    if (f[sensor_fifo_pkg::F_ACC]) n = n + sensor_fifo_pkg::BYTES_AXES;
    if (f[sensor_fifo_pkg::F_AUX]) n = n + sensor_fifo_pkg::BYTES_AXES;
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] downs_ff, wtm_lo_ff, wtm_hi_ff, cfg_a_ff, cfg_b_ff, aux_id_ff, rdata_ff;
  logic [7:0] nxt_downs, nxt_wtm_lo, nxt_wtm_hi, nxt_cfg_a, nxt_cfg_b, nxt_aux_id, nxt_rdata;

  // Writes keep reserved bits at zero; unmapped reads return zero
  always_comb begin
    nxt_downs  = downs_ff;
    nxt_wtm_lo = wtm_lo_ff;
    nxt_wtm_hi = wtm_hi_ff;
    nxt_cfg_a  = cfg_a_ff;
    nxt_cfg_b  = cfg_b_ff;
    nxt_aux_id = aux_id_ff;
    nxt_rdata  = rdata_ff;
    if (reg_wr) begin
      if (reg_addr == sensor_fifo_pkg::ADDR_DOWNS) begin
        nxt_downs = reg_wdata & sensor_fifo_pkg::MASK_DOWNS; // RULE1
      end else if (reg_addr == sensor_fifo_pkg::ADDR_WTM_LO) begin
        nxt_wtm_lo = reg_wdata; // RULE3
      end else if (reg_addr == sensor_fifo_pkg::ADDR_WTM_HI) begin
        nxt_wtm_hi = reg_wdata & sensor_fifo_pkg::MASK_WTM_HI; // RULE4
      end else if (reg_addr == sensor_fifo_pkg::ADDR_CFG_A) begin
        nxt_cfg_a = reg_wdata & sensor_fifo_pkg::MASK_CFG_A;
      end else if (reg_addr == sensor_fifo_pkg::ADDR_CFG_B) begin
        nxt_cfg_b = reg_wdata & sensor_fifo_pkg::MASK_CFG_B;
      end else if (reg_addr == sensor_fifo_pkg::ADDR_AUX_ID) begin
        nxt_aux_id = reg_wdata & sensor_fifo_pkg::MASK_AUX_ID; // RULE13
      end
    end
    if (reg_rd) begin
      if (reg_addr == sensor_fifo_pkg::ADDR_DOWNS) nxt_rdata = downs_ff;
      else if (reg_addr == sensor_fifo_pkg::ADDR_WTM_LO) nxt_rdata = wtm_lo_ff;
      else if (reg_addr == sensor_fifo_pkg::ADDR_WTM_HI) nxt_rdata = wtm_hi_ff;
      else if (reg_addr == sensor_fifo_pkg::ADDR_CFG_A) nxt_rdata = cfg_a_ff;
      else if (reg_addr == sensor_fifo_pkg::ADDR_CFG_B) nxt_rdata = cfg_b_ff;
      else if (reg_addr == sensor_fifo_pkg::ADDR_AUX_ID) nxt_rdata = aux_id_ff;
      else nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      downs_ff  <= sensor_fifo_pkg::RST_DOWNS;
      wtm_lo_ff <= sensor_fifo_pkg::RST_WTM_LO;
      wtm_hi_ff <= sensor_fifo_pkg::RST_WTM_HI;
      cfg_a_ff  <= sensor_fifo_pkg::RST_CFG_A;
      cfg_b_ff  <= sensor_fifo_pkg::RST_CFG_B;
      aux_id_ff <= sensor_fifo_pkg::RST_AUX_ID;
      rdata_ff  <= 8'h00;
    end else begin
      downs_ff  <= nxt_downs;
      wtm_lo_ff <= nxt_wtm_lo;
      wtm_hi_ff <= nxt_wtm_hi;
      cfg_a_ff  <= nxt_cfg_a;
      cfg_b_ff  <= nxt_cfg_b;
      aux_id_ff <= nxt_aux_id;
      rdata_ff  <= nxt_rdata;
    end
  end

  logic        filt_sel, stop_full, time_en, acc_en, aux_en, hdr_en, tag_a_en, tag_b_en;
  logic [2:0]  downs;
  logic [12:0] wtm_level;
  assign filt_sel  = downs_ff[sensor_fifo_pkg::BIT_FILT];
  assign downs     = downs_ff[sensor_fifo_pkg::BIT_DS_LO +: 3];
  assign stop_full = cfg_a_ff[sensor_fifo_pkg::BIT_STOP_FULL];
  assign time_en   = cfg_a_ff[sensor_fifo_pkg::BIT_TIME_EN];
  assign acc_en    = cfg_b_ff[sensor_fifo_pkg::BIT_ACC_EN];
  assign aux_en    = cfg_b_ff[sensor_fifo_pkg::BIT_AUX_EN];
  assign hdr_en    = cfg_b_ff[sensor_fifo_pkg::BIT_HDR_EN];
  assign tag_a_en  = cfg_b_ff[sensor_fifo_pkg::BIT_TAG_A];
  assign tag_b_en  = cfg_b_ff[sensor_fifo_pkg::BIT_TAG_B];
  assign wtm_level = {wtm_hi_ff[4:0], wtm_lo_ff}; // RULE4
  assign reg_rdata      = rdata_ff;
  assign aux_slave_addr = aux_id_ff[7:1]; // RULE13

  // ----------------------------------------------------------------
  // Interrupt line synchronisers and downsampling counter
  // ----------------------------------------------------------------
  // Lines are asynchronous pins; level accepted once stages 2 and 3 agree
  logic [2:0] sync_a_ff, sync_b_ff, nxt_sync_a, nxt_sync_b;
  logic       line_a_ff, line_b_ff, nxt_line_a, nxt_line_b;
  logic [6:0] ds_cnt_ff, nxt_ds_cnt, ds_max;
  logic       acc_tick;

  assign ds_max   = (7'h01 << downs) - 7'h01; // RULE1
  assign acc_tick = acc_valid && (ds_cnt_ff == 7'h00); // RULE1

  always_comb begin
    nxt_sync_a = {sync_a_ff[1:0], irq_line_a};
    nxt_sync_b = {sync_b_ff[1:0], irq_line_b};
    nxt_line_a = (sync_a_ff[1] == sync_a_ff[2]) ? sync_a_ff[2] : line_a_ff;
    nxt_line_b = (sync_b_ff[1] == sync_b_ff[2]) ? sync_b_ff[2] : line_b_ff;
    nxt_ds_cnt = ds_cnt_ff;
    if (acc_valid) begin
      nxt_ds_cnt = (ds_cnt_ff >= ds_max) ? 7'h00 : ds_cnt_ff + 7'h01; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a_ff <= 3'h0;
      sync_b_ff <= 3'h0;
      line_a_ff <= 1'b0;
      line_b_ff <= 1'b0;
      ds_cnt_ff <= 7'h00;
    end else begin
      sync_a_ff <= nxt_sync_a;
      sync_b_ff <= nxt_sync_b;
      line_a_ff <= nxt_line_a;
      line_b_ff <= nxt_line_b;
      ds_cnt_ff <= nxt_ds_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Frame assembly and FIFO
  // ----------------------------------------------------------------
  // A frame is written on each kept acc sample, or on aux samples when
  // acceleration storage is off. Headerless mode relies on the host
  // running all enabled sources at one rate. [RULE8]
  logic [FW-1:0] wr_frame, fifo_data;
  logic          wr_req, fifo_in_ready, fifo_valid, fifo_pop, wr_push, wr_drop;
  assign wr_req = (acc_tick && acc_en) || (aux_valid && aux_en && !acc_en);

  always_comb begin
    wr_frame = '0;
    wr_frame[sensor_fifo_pkg::F_HDR]   = hdr_en; // RULE7
    wr_frame[sensor_fifo_pkg::F_TAG_A] = tag_a_en && line_a_ff; // RULE11
    wr_frame[sensor_fifo_pkg::F_TAG_B] = tag_b_en && line_b_ff; // RULE12
    wr_frame[sensor_fifo_pkg::F_ACC]   = acc_en; // RULE10
    wr_frame[sensor_fifo_pkg::F_AUX]   = aux_en; // RULE9
    if (acc_en) begin
      wr_frame[sensor_fifo_pkg::AXIS_W +: 48] = filt_sel ? acc_filt_data : acc_raw_data; // RULE2
    end
    if (aux_en) begin
      wr_frame[47:0] = aux_data; // RULE9
    end
  end

  // Overwrite keeps the freshest data; stop mode refuses new frames
  frame_fifo #(
    .W     (FW),
    .DEPTH (sensor_fifo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wr_req),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_frame),
    .overwrite (!stop_full), // RULE5 RULE14
    .out_valid (fifo_valid),
    .out_ready (out_ready),
    .out_data  (fifo_data),
    .full      (fifo_full)
  );

  assign sample_ready = fifo_in_ready; // RULE5
  assign wr_push  = wr_req && fifo_in_ready;
  assign fifo_pop = fifo_valid && out_ready;
  assign wr_drop  = wr_push && fifo_full && !fifo_pop; // RULE14

  // ----------------------------------------------------------------
  // Fill level, watermark and sensor-time frame
  // ----------------------------------------------------------------
  logic [12:0] fill_ff, nxt_fill;
  logic        wtm_ff, nxt_wtm, time_pend_ff, nxt_time_pend;
  logic [23:0] time_ff, nxt_time;
  logic [FW-1:0] time_frame;

  always_comb begin
    nxt_fill = fill_ff + (wr_push ? frame_bytes(wr_frame) : 13'h0000)
             - ((fifo_pop || wr_drop) ? frame_bytes(fifo_data) : 13'h0000);
    // Compare with the level that stands next cycle, so a level write never lags
    nxt_wtm  = (nxt_fill >= {nxt_wtm_hi[4:0], nxt_wtm_lo}); // RULE15
    nxt_time_pend = time_pend_ff;
    nxt_time = time_ff;
    // Last data frame leaves the FIFO empty: arm one time frame
    if (fifo_pop && !wr_push && (fill_ff == frame_bytes(fifo_data))) begin
      nxt_time_pend = 1'b1; // RULE6
      nxt_time      = sensor_time;
    end else if (!fifo_valid && out_ready && time_pend_ff) begin
      nxt_time_pend = 1'b0;
    end
    if (wr_push) nxt_time_pend = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fill_ff      <= 13'h0000;
      wtm_ff       <= 1'b0;
      time_pend_ff <= 1'b0;
      time_ff      <= 24'h000000;
    end else begin
      fill_ff      <= nxt_fill;
      wtm_ff       <= nxt_wtm;
      time_pend_ff <= nxt_time_pend;
      time_ff      <= nxt_time;
    end
  end

  always_comb begin
    time_frame = '0;
    time_frame[sensor_fifo_pkg::F_TIME] = 1'b1;
    time_frame[sensor_fifo_pkg::F_HDR]  = hdr_en;
    time_frame[23:0] = time_ff;
  end

  assign fill_bytes = fill_ff;
  assign wtm_event  = wtm_ff;
  assign out_valid  = fifo_valid || (time_pend_ff && time_en); // RULE6
  assign out_data   = fifo_valid ? fifo_data : time_frame;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ds_gap;
    @(posedge clk) disable iff (rst)
      acc_tick && downs == 3'h1 && !reg_wr |=> ds_cnt_ff == 7'h01 && !acc_tick;
  endproperty
  a_ds_gap: assert property (p_ds_gap) else $error("downsample kept adjacent sample"); // RULE1

  property p_filt;
    @(posedge clk) disable iff (rst)
      wr_push && acc_en |-> wr_frame[95:48] == (filt_sel ? acc_filt_data : acc_raw_data);
  endproperty
  a_filt: assert property (p_filt) else $error("wrong acc source"); // RULE2

  property p_wtm_lo;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == sensor_fifo_pkg::ADDR_WTM_LO |=> wtm_level[7:0] == $past(reg_wdata);
  endproperty
  a_wtm_lo: assert property (p_wtm_lo) else $error("watermark low not stored"); // RULE3

  property p_wtm_reset;
    @(posedge clk) rst |=> wtm_level == 13'h0200 && aux_slave_addr == 7'h10;
  endproperty
  a_wtm_reset: assert property (p_wtm_reset) else $error("bad reset level"); // RULE4

  property p_stop;
    @(posedge clk) disable iff (rst)
      stop_full && fifo_full && !fifo_pop && wr_req |=> fill_bytes == $past(fill_bytes);
  endproperty
  a_stop: assert property (p_stop) else $error("write while full in stop mode"); // RULE5

  property p_time;
    @(posedge clk) disable iff (rst)
      time_en && fifo_pop && !wr_push && fill_ff == frame_bytes(fifo_data)
      |=> out_valid && out_data[sensor_fifo_pkg::F_TIME];
  endproperty
  a_time: assert property (p_time) else $error("no time frame after drain"); // RULE6

  property p_frame_bits;
    @(posedge clk) disable iff (rst)
      wr_push |-> wr_frame[sensor_fifo_pkg::F_HDR] == hdr_en
        && wr_frame[sensor_fifo_pkg::F_AUX] == aux_en && wr_frame[sensor_fifo_pkg::F_ACC] == acc_en;
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame content bits wrong"); // RULE7

  property p_tag;
    @(posedge clk) disable iff (rst)
      wr_push |-> wr_frame[sensor_fifo_pkg::F_TAG_A] == (tag_a_en && line_a_ff)
        && wr_frame[sensor_fifo_pkg::F_TAG_B] == (tag_b_en && line_b_ff);
  endproperty
  a_tag: assert property (p_tag) else $error("tag bits wrong"); // RULE11

  property p_overwrite;
    @(posedge clk) disable iff (rst)
      !stop_full && fifo_full && wr_req |-> sample_ready ##1 fifo_full;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("overwrite refused"); // RULE14

  property p_wtm_evt;
    @(posedge clk) disable iff (rst) ##1 wtm_event == (fill_bytes >= wtm_level);
  endproperty
  a_wtm_evt: assert property (p_wtm_evt) else $error("watermark event mismatch"); // RULE15

  c_full: cover property (@(posedge clk) disable iff (rst) fifo_full && wr_drop);
  c_time: cover property (@(posedge clk) disable iff (rst) out_valid && out_data[sensor_fifo_pkg::F_TIME] && out_ready);
  c_wtm: cover property (@(posedge clk) disable iff (rst) !wtm_event ##1 wtm_event);
endmodule

`default_nettype wire

// ==== host_reader.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Frame reader standing in for the host
// ----------------------------------------------------------------
module host_reader (
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  // Pace control from the bench
  input  wire logic                                 hold,
  input  wire logic                                 slow,
  // Frame read-out
  input  wire logic                                 out_valid,
  input  wire logic [sensor_fifo_pkg::FRAME_W-1:0]  out_data,
  output logic                                      out_ready
);
  logic                                 ph_ff;
  logic [sensor_fifo_pkg::FRAME_W-1:0]  got [$];

  // Slow mode takes only every other cycle, so a drain runs at half rate
  always @(posedge clk) begin
    ph_ff <= rst ? 1'b0 : ~ph_ff;
    if (!rst && out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end

  // Ready only moves after an edge, never mid-cycle
  assign out_ready = !hold && (!slow || ph_ff);
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define G host_reader_inst.got
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR at %0t: got %h exp %h", $time, a, e); end end

module tb_top;
  // ----------------------------------------------------------------
  // Clock, reset and stimulus
  // ----------------------------------------------------------------
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [6:0]   reg_addr = 7'h00;
  logic [7:0]   reg_wdata = 8'h00;
  logic         acc_valid = 1'b0;
  logic [47:0]  acc_raw_data = 48'h0;
  logic [47:0]  acc_filt_data = 48'h0;
  logic         aux_valid = 1'b0;
  logic [47:0]  aux_data = 48'h5A5A_1234_9876;
  logic [23:0]  sensor_time = 24'h00C0DE;
  logic         irq_line_a = 1'b0;
  logic         irq_line_b = 1'b0;
  logic         hold = 1'b1;
  logic         slow = 1'b0;
  logic         sample_ready;
  logic [7:0]   reg_rdata;
  logic         out_valid;
  logic         out_ready;
  logic [101:0] out_data;
  logic         fifo_full;
  logic [12:0]  fill_bytes;
  logic         wtm_event;
  logic [6:0]   aux_slave_addr;
  int           n_errors = 0;
  int           checked = 0;
  int           cyc = 0;
  int           seq = 1;
  int           s0;
  // Register map, reset values and writable masks
  logic [6:0]   ra [6] = '{7'h45, 7'h46, 7'h47, 7'h48, 7'h49, 7'h4B};
  logic [7:0]   rv [6] = '{8'h80, 8'h00, 8'h02, 8'h02, 8'h10, 8'h20};
  logic [7:0]   rm [6] = '{8'hF0, 8'hFF, 8'h1F, 8'h03, 8'h7C, 8'hFE};

  always #5 clk = ~clk;

  sensor_fifo_config sensor_fifo_config_inst (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_raw_data(acc_raw_data),
    .acc_filt_data(acc_filt_data), .aux_valid(aux_valid), .aux_data(aux_data),
    .sensor_time(sensor_time), .sample_ready(sample_ready),
    .irq_line_a(irq_line_a), .irq_line_b(irq_line_b), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .fifo_full(fifo_full),
    .fill_bytes(fill_bytes), .wtm_event(wtm_event), .aux_slave_addr(aux_slave_addr)
  );

  host_reader host_reader_inst (
    .clk(clk), .rst(rst), .hold(hold), .slow(slow),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready)
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data lands on the same edge that takes the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // Each sample carries a running sequence number for order checks
  task automatic push(input int n);
    repeat (n) begin
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_raw_data <= {16'hA0A0, seq};
      acc_filt_data <= {16'hF1F1, seq};
      seq++;
      @(posedge clk);
      acc_valid <= 1'b0;
    end
    #1;
  endtask

  // Fixed window covers eight frames plus a time frame in slow mode
  task automatic drain(input logic sl);
    `G.delete();
    @(posedge clk);
    slow <= sl; hold <= 1'b0;
    repeat (40) @(posedge clk);
    hold <= 1'b1;
    #1;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], 8'hFF);
      rd(ra[i], rm[i]);
    end
    wr(7'h4A, 8'hFF);
    rd(7'h4A, 8'h00);
    `CHK(aux_slave_addr, 7'h7F)
    wr(7'h4B, 8'h42);
    #1 `CHK(aux_slave_addr, 7'h21)
    done("registers");
    // Watermark at 14 bytes, two header plus accel frames of 7 bytes
    wr(7'h45, 8'h80);
    wr(7'h48, 8'h00);
    wr(7'h49, 8'h50);
    wr(7'h46, 8'h0E);
    wr(7'h47, 8'h00);
    push(1);
    `CHK({fill_bytes, wtm_event}, {13'h0007, 1'b0})
    push(1);
    `CHK({fill_bytes, wtm_event}, {13'h000E, 1'b1})
    drain(1'b1);
    `CHK(`G[0][101:96], 6'b010010)
    `CHK(`G[0][95:80], 16'hF1F1)
    done("watermark");
    // Downsampling factors 1, 2, 4 and 8, unfiltered source
    for (int d = 0; d < 4; d++) begin
      wr(7'h45, {1'b0, 3'(d), 4'h0});
      push(8);
      `CHK(fill_bytes, 13'((8 >> d) * 7))
      drain(1'b0);
      `CHK(`G[0][95:80], 16'hA0A0)
    end
    done("downsample");
    // Overwrite mode first, then stop-on-full
    wr(7'h45, 8'h80);
    for (int m = 0; m < 2; m++) begin
      wr(7'h48, 8'(m));
      s0 = seq;
      push(10);
      `CHK({fifo_full, fill_bytes}, {1'b1, 13'h0038})
      `CHK(sample_ready, ~1'(m))
      drain(1'b1);
      `CHK(`G.size(), 8)
      `CHK(`G[0][79:48], 32'(s0 + (m == 1 ? 0 : 2)))
    end
    done("full");
    // Sensor-time frame follows the last data frame
    wr(7'h48, 8'h02);
    push(1);
    drain(1'b0);
    `CHK(`G.size(), 2)
    `CHK({`G[0][101], `G[1][101]}, 2'b01)
    `CHK(`G[1][23:0], sensor_time)
    done("time");
    // Headerless accel plus aux, one shared cadence
    @(posedge clk);
    irq_line_a <= 1'b1;
    wr(7'h49, 8'h6C);
    repeat (6) @(posedge clk);
    push(1);
    `CHK(fill_bytes, 13'h000C)
    drain(1'b0);
    `CHK(`G[0][101:96], 6'b001011)
    `CHK(`G[0][47:0], aux_data)
    // Aux-only frames tagged with the second line only
    @(posedge clk);
    irq_line_b <= 1'b1;
    wr(7'h49, 8'h24);
    repeat (6) @(posedge clk);
    aux_valid <= 1'b1;
    @(posedge clk);
    aux_valid <= 1'b0;
    #1 `CHK(fill_bytes, 13'h0006)
    drain(1'b0);
    `CHK(`G[0][101:96], 6'b000101)
    done("sources");
    print_verdict();
  end
endmodule

`default_nettype wire
